// ### common/motion_regs_consts.svh
`ifndef MOTION_REGS_CONSTS_SVH
`define MOTION_REGS_CONSTS_SVH
`define DATA_W 12
`define ADDR_W 4
// Write map
`define WA_REVERSE_ANGLE 4'h0
`define WA_INPUT_1 4'h1
`define WA_INPUT_2 4'h2
`define WA_INPUT_3 4'h3
`define WA_FORWARD_ANGLE 4'h4
`define WA_SYS_CONTROL 4'hD
// Read map
`define RA_RESULT_0 4'h0
`define RA_RESULT_1 4'h1
`define RA_RESULT_2 4'h2
`define RA_RESULT_3 4'h3
`define RA_CONV_V 4'h5
`define RA_CONV_W 4'h6
`define RA_CONV_AUX 4'h7
`define RA_CONV_U 4'h8
`define RA_SYS_CONTROL 4'hD
`define RA_SYS_STATUS 4'hE
// Control bits
`define CTL_RESERVED_MASK 12'h003
`define CTL_U_EN 3
`define CTL_AUX_EN 4
`define CTL_CLK_DIV2 5
`define CTL_ROT_IEN 6
`define CTL_CONV_IEN 7
`define CTL_IRQ_LEVEL 8
`define CTL_THREE_OF_THREE 10
`define CTL_RESET 12'h000
// Status bits
`define ST_CONV_DONE 0
`define ST_ROT_DONE 1
`define ST_RESULT_VALID 4
`define ST_ANY_IRQ 11
`define ST_CLEAR_MASK 12'h803
// Converter keeps 11 bits; bit 0 forced zero
`define CONV_LSB_MASK 12'hFFE
// Edge-style request pulse length in system clock cycles
`define IRQ_PULSE_CYCLES 4'h4
`endif

// ### common/motion_regs_pkg.sv
package motion_regs_pkg;
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic [3:0] addr;
        logic [11:0] data;
    } host_bus_t;

    typedef struct packed {
        logic uEn;
        logic auxEn;
        logic threePhase;
    } conv_select_t;

    typedef enum logic [1:0] {
        ROT_IDLE = 2'b00,
        ROT_FORWARD = 2'b01,
        ROT_REVERSE = 2'b10
    } rot_kind_t;

    typedef struct packed {
        rot_kind_t kind;
        logic threeOfThree;
        logic [11:0] angle;
        logic [11:0] in1;
        logic [11:0] in2;
        logic [11:0] in3;
    } rot_cmd_t;
endpackage

// ### hw/motion_coproc_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "motion_regs_consts.svh"

// Summary of operation
// - Converter results read with bit 0 forced to zero.
// - Write to forward angle starts forward rotation with direct, quadrature inputs.
// - Write to reverse angle starts reverse rotation with three inputs.
// - Angles are unsigned fractions of a turn, 4096 counts per turn.
// - Control bits 3 and 4 select converted channels and phase mode.
// - Control bit 5 divides external clock by two.
// - Control bit 6 enables rotation-complete interrupt.
// - Control bit 7 enables conversion-complete interrupt.
// - Control bit 8 picks edge or level request style.
// - Control bit 10 picks three-of-three or two-of-three reverse mode.
// - Status bit 0 sets on conversion done when enabled.
// - Status bit 1 sets on rotation done when enabled.
// - Status bit 4 shows rotation results valid.
// - Status bit 11 sets when any interrupt source fires.
// - Status read clears bits 0, 1, 11, keeps valid bit.
// - Writes latch on rising write strobe while chip select low.
// - Four address lines; reads and writes decode separate maps.
// - Control at 1101 read and write; status at read 1110.
module motion_coproc_ctrl_status_regs
    import motion_regs_pkg::*;
#(
    parameter int dataWidth = `DATA_W, // Register word width
    parameter int addrWidth = `ADDR_W // Register address width
)
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic csN, // Chip select pin, active low
    input wire logic rdN, // Read strobe pin, active low
    input wire logic wrN, // Write strobe pin, active low
    input wire logic [addrWidth-1:0] addr, // Register address pins
    input wire logic [dataWidth-1:0] dataIn, // Data bus input
    output logic [dataWidth-1:0] dataOut, // Data bus output
    output logic dataOe, // Data bus drive enable
    input wire logic [11:0] convU, // Raw converter result U
    input wire logic [11:0] convV, // Raw converter result V
    input wire logic [11:0] convW, // Raw converter result W
    input wire logic [11:0] convAux, // Raw converter result AUX
    input wire logic convDone, // Conversion sequence done pulse
    input wire logic [11:0] rotResult0, // Rotation result word 0
    input wire logic [11:0] rotResult1, // Rotation result word 1
    input wire logic [11:0] rotResult2, // Rotation result word 2
    input wire logic [11:0] rotResult3, // Rotation result word 3
    input wire logic rotDone, // Rotation complete pulse
    output rot_cmd_t rotCmd, // Rotation command, held
    output logic rotStart, // Rotation start pulse
    output conv_select_t convSel, // Channel selection
    output logic clkDiv2, // Divide external clock by two
    output logic irqN // Interrupt request pin, active low
);

    // Synchronised pin copies; stage 1 is only read by stage 2
    host_bus_t busMeta, busSync;
    logic wrNPrev, rdNPrev;
    logic [11:0] ctrl, next_ctrl;
    logic [11:0] angleFwd, next_angleFwd;
    logic [11:0] angleRev, next_angleRev;
    logic [11:0] in1, next_in1, in2, next_in2, in3, next_in3;
    logic stConv, next_stConv, stRot, next_stRot;
    logic stValid, next_stValid, stAny, next_stAny;
    rot_cmd_t next_rotCmd;
    logic next_rotStart;
    logic [11:0] next_dataOut;
    logic next_dataOe;
    logic [3:0] pulseCnt, next_pulseCnt;
    logic next_irqN;
    logic wrRise, rdFall, convEvt, rotEvt, anyEvt;
    logic [11:0] statusWord;

    // Force bit 0 to zero since the converter resolves 11 bits
    function automatic logic [11:0] convWord(input logic [11:0] raw);
        return raw & `CONV_LSB_MASK;
    endfunction

    // Word and address widths are tied to the register map and carriers
    if (dataWidth != `DATA_W || addrWidth != `ADDR_W) begin
        $error("Register bus widths other than the defaults are unsupported");
    end

    // Pin synchroniser; async strobes may glitch the decode otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busMeta <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
            busSync <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
            wrNPrev <= 1'b1;
            rdNPrev <= 1'b1;
        end else begin
            busMeta <= '{csN: csN, rdN: rdN, wrN: wrN, addr: addr,
                         data: dataIn};
            busSync <= busMeta;
            wrNPrev <= busSync.wrN;
            rdNPrev <= busSync.rdN;
        end
    end

    // Write taken on rising write strobe with chip select low
    assign wrRise = busSync.wrN && !wrNPrev && !busSync.csN;
    // Status read is counted once, at the falling read strobe
    assign rdFall = !busSync.rdN && rdNPrev && !busSync.csN;
    assign convEvt = convDone && ctrl[`CTL_CONV_IEN];
    assign rotEvt = rotDone && ctrl[`CTL_ROT_IEN];
    assign anyEvt = convEvt || rotEvt;

    // Status word assembly
    always_comb begin
        statusWord = '0;
        statusWord[`ST_CONV_DONE] = stConv;
        statusWord[`ST_ROT_DONE] = stRot;
        statusWord[`ST_RESULT_VALID] = stValid;
        statusWord[`ST_ANY_IRQ] = stAny;
    end

    // Write-side registers and rotation start
    always_comb begin
        next_ctrl = ctrl;
        next_angleFwd = angleFwd;
        next_angleRev = angleRev;
        next_in1 = in1;
        next_in2 = in2;
        next_in3 = in3;
        next_rotCmd = rotCmd;
        next_rotStart = 1'b0;
        if (wrRise) begin
            // Separate write map from the read map
            if (busSync.addr == `WA_SYS_CONTROL) begin
                // Reserved bits held at zero whatever the host sends
                next_ctrl = busSync.data & ~`CTL_RESERVED_MASK;
            end else if (busSync.addr == `WA_INPUT_1) begin
                next_in1 = busSync.data;
            end else if (busSync.addr == `WA_INPUT_2) begin
                next_in2 = busSync.data;
            end else if (busSync.addr == `WA_INPUT_3) begin
                next_in3 = busSync.data;
                // Inputs are copied with the angle; later writes cannot
                // disturb a rotation that is already running
            end else if (busSync.addr == `WA_FORWARD_ANGLE) begin
                // Full 12-bit unsigned turn fraction, wraps naturally
                next_angleFwd = busSync.data;
                next_rotCmd = '{kind: ROT_FORWARD,
                    threeOfThree: ctrl[`CTL_THREE_OF_THREE],
                    angle: busSync.data, in1: in1, in2: in2,
                    in3: in3};
                next_rotStart = 1'b1;
            end else if (busSync.addr == `WA_REVERSE_ANGLE) begin
                next_angleRev = busSync.data;
                next_rotCmd = '{kind: ROT_REVERSE,
                    threeOfThree: ctrl[`CTL_THREE_OF_THREE],
                    angle: busSync.data, in1: in1, in2: in2,
                    in3: in3};
                next_rotStart = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `CTL_RESET;
            angleFwd <= '0;
            angleRev <= '0;
            in1 <= '0;
            in2 <= '0;
            in3 <= '0;
            rotCmd <= '0;
            rotStart <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            angleFwd <= next_angleFwd;
            angleRev <= next_angleRev;
            in1 <= next_in1;
            in2 <= next_in2;
            in3 <= next_in3;
            rotCmd <= next_rotCmd;
            rotStart <= next_rotStart;
        end
    end

    // Control outputs, registered so they come from flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            convSel <= '0;
            clkDiv2 <= 1'b0;
        end else begin
            convSel <= '{uEn: next_ctrl[`CTL_U_EN],
                         auxEn: next_ctrl[`CTL_AUX_EN],
                         threePhase: next_ctrl[`CTL_U_EN]};
            clkDiv2 <= next_ctrl[`CTL_CLK_DIV2];
        end
    end

    // Sticky status; a set in the clearing cycle wins
    always_comb begin
        next_stConv = stConv;
        next_stRot = stRot;
        next_stAny = stAny;
        next_stValid = stValid;
        if (rdFall && busSync.addr == `RA_SYS_STATUS) begin
            next_stConv = 1'b0;
            next_stRot = 1'b0;
            next_stAny = 1'b0;
        end
        if (convEvt) begin
            next_stConv = 1'b1;
        end
        if (rotEvt) begin
            next_stRot = 1'b1;
        end
        if (anyEvt) begin
            next_stAny = 1'b1;
        end
        // Results stale while a rotation runs, valid once it ends
        // Valid ignores the enables: it reports results, not requests
        if (rotStart) begin
            next_stValid = 1'b0;
        end
        if (rotDone) begin
            next_stValid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stConv <= 1'b0;
            stRot <= 1'b0;
            stAny <= 1'b0;
            stValid <= 1'b0;
        end else begin
            stConv <= next_stConv;
            stRot <= next_stRot;
            stAny <= next_stAny;
            stValid <= next_stValid;
        end
    end

    // Read mux; unmapped read addresses return zero
    // Drive enable trails the pins by the two sync stages plus one
    always_comb begin
        next_dataOe = !busSync.csN && !busSync.rdN;
        next_dataOut = '0;
        if (busSync.addr == `RA_RESULT_0) begin
            next_dataOut = rotResult0;
        end else if (busSync.addr == `RA_RESULT_1) begin
            next_dataOut = rotResult1;
        end else if (busSync.addr == `RA_RESULT_2) begin
            next_dataOut = rotResult2;
        end else if (busSync.addr == `RA_RESULT_3) begin
            next_dataOut = rotResult3;
        end else if (busSync.addr == `RA_CONV_V) begin
            next_dataOut = convWord(convV);
        end else if (busSync.addr == `RA_CONV_W) begin
            next_dataOut = convWord(convW);
        end else if (busSync.addr == `RA_CONV_AUX) begin
            next_dataOut = convWord(convAux);
        end else if (busSync.addr == `RA_CONV_U) begin
            next_dataOut = convWord(convU);
        end else if (busSync.addr == `RA_SYS_CONTROL) begin
            next_dataOut = ctrl;
        end else if (busSync.addr == `RA_SYS_STATUS) begin
            next_dataOut = statusWord;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dataOut <= '0;
            dataOe <= 1'b0;
        end else begin
            dataOut <= next_dataOut;
            dataOe <= next_dataOe;
        end
    end

    // Request pin: level holds while flagged; edge gives a short pulse
    // Edge style ends early if the host read clears the flag first
    always_comb begin
        next_pulseCnt = pulseCnt;
        if (anyEvt) begin
            next_pulseCnt = `IRQ_PULSE_CYCLES;
        end else if (pulseCnt != 4'h0) begin
            next_pulseCnt = pulseCnt - 4'h1;
        end
        if (ctrl[`CTL_IRQ_LEVEL]) begin
            next_irqN = !next_stAny;
        end else begin
            next_irqN = !(next_stAny && next_pulseCnt != 4'h0);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulseCnt <= 4'h0;
            irqN <= 1'b1;
        end else begin
            pulseCnt <= next_pulseCnt;
            irqN <= next_irqN;
        end
    end

endmodule

// ### tb/motion_regs_properties.sv
`timescale 1ns/1ps
module motion_regs_properties
    import motion_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic dataOe,
    input wire logic convDone,
    input wire logic rotDone,
    input rot_cmd_t rotCmd,
    input wire logic rotStart,
    input conv_select_t convSel,
    input wire logic clkDiv2,
    input wire logic irqN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [3:0] sinceEv;
    // Saturating age of the last completion event
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            sinceEv <= 4'hF;
        else if (convDone || rotDone)
            sinceEv <= 4'h0;
        else if (sinceEv != 4'hF)
            sinceEv <= sinceEv + 4'h1;
    end
    property p_rot_kind; rotStart |-> rotCmd.kind != ROT_IDLE; endproperty
    property p_start_pulse; rotStart |=> !rotStart; endproperty
    property p_start_write;
        rotStart |-> $past(wrN, 1) && !$past(wrN, 6);
    endproperty
    property p_sel_phase; convSel.threePhase == convSel.uEn; endproperty
    property p_sel_write;
        !$stable(convSel) |-> $past(wrN, 1) && !$past(wrN, 6);
    endproperty
    property p_div_write;
        $changed(clkDiv2) |-> $past(wrN, 1) && !$past(wrN, 6);
    endproperty
    property p_oe_cause;
        $rose(dataOe) |-> !$past(rdN, 2) && !$past(csN, 2);
    endproperty
    property p_oe_idle; rdN [*5] |-> !dataOe; endproperty
    property p_irq_cause; $fell(irqN) |-> sinceEv < 4'h5; endproperty
    a_rot_kind: assert property (p_rot_kind)
        else $error("Start pulse with idle kind");
    a_start_pulse: assert property (p_start_pulse)
        else $error("Start pulse too long");
    a_start_write: assert property (p_start_write)
        else $error("Start without a write strobe");
    a_sel_phase: assert property (p_sel_phase)
        else $error("Phase mode differs from U enable");
    a_sel_write: assert property (p_sel_write)
        else $error("Channel select moved without write");
    a_div_write: assert property (p_div_write)
        else $error("Divider moved without write");
    a_oe_cause: assert property (p_oe_cause)
        else $error("Bus driven without read");
    a_oe_idle: assert property (p_oe_idle)
        else $error("Bus driven while idle");
    a_irq_cause: assert property (p_irq_cause)
        else $error("Request without an event");
    c_forward: cover property (rotStart && rotCmd.kind == ROT_FORWARD);
    c_reverse: cover property (rotStart && rotCmd.kind == ROT_REVERSE);
    c_irq: cover property ($fell(irqN));
endmodule

bind motion_coproc_ctrl_status_regs motion_regs_properties chk (
    .clk(clk), .rstn(rstn), .csN(csN), .rdN(rdN), .wrN(wrN),
    .dataOe(dataOe), .convDone(convDone), .rotDone(rotDone),
    .rotCmd(rotCmd), .rotStart(rotStart), .convSel(convSel),
    .clkDiv2(clkDiv2), .irqN(irqN)
);

// ### tb/rot_conv_model.sv
`timescale 1ns/1ps
module rot_conv_model
    import motion_regs_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic rotStart, // Start pulse
    input rot_cmd_t rotCmd, // Held command
    input wire logic convKick, // Bench ends a conversion
    output logic rotDone, // Completion pulse
    output logic [3:0][11:0] res, // Result words 0..3
    output logic convDone, // Conversion done pulse
    output logic [3:0][11:0] conv // U, V, W, aux
);
    logic [3:0] busyCnt;
    // Rotation takes eight cycles; results hold until the next one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busyCnt <= 4'h0;
            rotDone <= 1'b0;
            convDone <= 1'b0;
            res <= '0;
        end else begin
            rotDone <= (busyCnt == 4'h1);
            convDone <= convKick;
            if (rotStart)
                busyCnt <= 4'h8;
            else if (busyCnt != 4'h0)
                busyCnt <= busyCnt - 4'h1;
            if (busyCnt == 4'h1)
                res <= {rotCmd.in3, rotCmd.in2, rotCmd.in1, rotCmd.angle};
        end
    end
    // Bit 0 set on purpose so the forced zero shows
    assign conv = {12'h555, 12'hC01, 12'h3FF, 12'h801};
endmodule

// ### tb/test_motion_coproc_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "motion_regs_consts.svh"
module test_motion_coproc_ctrl_status_regs
    import motion_regs_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic csN = 1'b1;
    logic rdN = 1'b1;
    logic wrN = 1'b1;
    logic convKick = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [11:0] dataIn = 12'h000;
    logic [11:0] dataOut;
    logic [11:0] lows;
    logic dataOe, rotDone, convDone, rotStart, clkDiv2, irqN;
    logic [3:0][11:0] res, conv;
    rot_cmd_t rotCmd;
    conv_select_t convSel;
    int nErrors = 0;
    int testsRun = 0;

    always #50 clk = ~clk;

    motion_coproc_ctrl_status_regs dut (.clk(clk), .rstn(rstn),
        .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .convU(conv[0]),
        .convV(conv[1]), .convW(conv[2]), .convAux(conv[3]),
        .convDone(convDone), .rotResult0(res[0]), .rotResult1(res[1]),
        .rotResult2(res[2]), .rotResult3(res[3]), .rotDone(rotDone),
        .rotCmd(rotCmd), .rotStart(rotStart), .convSel(convSel),
        .clkDiv2(clkDiv2), .irqN(irqN));
    rot_conv_model far (.clk(clk), .rstn(rstn), .rotStart(rotStart),
        .rotCmd(rotCmd), .convKick(convKick), .rotDone(rotDone),
        .res(res), .convDone(convDone), .conv(conv));

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic endSim;
        if (nErrors == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Strobes held well past the two-stage pin synchroniser
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        addr = a;
        dataIn = d;
        csN = 1'b0;
        wrN = 1'b0;
        cyc(6);
        wrN = 1'b1;
        cyc(5);
        csN = 1'b1;
        cyc(3);
    endtask
    // Take the first driven word: status clears right behind it
    task automatic rd(input logic [3:0] a, input logic [11:0] exp);
        int i;
        addr = a;
        csN = 1'b0;
        rdN = 1'b0;
        for (i = 0; i < 10 && dataOe !== 1'b1; i++)
            cyc(1);
        if (i == 10) begin
            nErrors++;
            endSim();
        end
        chk(dataOut, exp);
        rdN = 1'b1;
        csN = 1'b1;
        cyc(5);
    endtask
    task automatic kick;
        convKick = 1'b1;
        cyc(1);
        convKick = 1'b0;
    endtask

    initial begin
        cyc(2);
        rstn = 1'b1;
        cyc(1);
        rd(`RA_SYS_CONTROL, `CTL_RESET);
        rd(`RA_SYS_STATUS, 12'h000);
        for (int k = 0; k < 4; k++) begin
            wr(`WA_SYS_CONTROL, 12'(k * 8));
            chk(12'(convSel), {9'h0, k[0], k[1], k[0]});
        end
        wr(`WA_SYS_CONTROL, 12'h5F8);
        chk(12'(clkDiv2), 12'h001);
        rd(`RA_SYS_CONTROL, 12'h5F8);
        rd(`RA_CONV_U, 12'h800);
        rd(`RA_CONV_V, 12'h3FE);
        rd(`RA_CONV_W, 12'hC00);
        rd(`RA_CONV_AUX, 12'h554);
        rd(4'h4, 12'h000);
        // Write strobe with chip select high must not land
        addr = `WA_SYS_CONTROL;
        dataIn = 12'h0F8;
        wrN = 1'b0;
        cyc(6);
        wrN = 1'b1;
        cyc(5);
        rd(`RA_SYS_CONTROL, 12'h5F8);
        // Forward rotation at half a turn, level request
        wr(`WA_INPUT_1, 12'h111);
        wr(`WA_INPUT_2, 12'h222);
        wr(`WA_FORWARD_ANGLE, 12'h800);
        chk(12'(rotCmd.kind), 12'(ROT_FORWARD));
        chk(rotCmd.in2, 12'h222);
        chk(12'(rotCmd.threeOfThree), 12'h001);
        cyc(8);
        chk(12'(irqN), 12'h000);
        rd(`RA_SYS_STATUS, 12'h812);
        rd(`RA_SYS_STATUS, 12'h010);
        chk(12'(irqN), 12'h001);
        rd(`RA_RESULT_0, 12'h800);
        // Reverse, rotation request off, edge style
        wr(`WA_SYS_CONTROL, 12'h080);
        wr(`WA_INPUT_3, 12'h333);
        wr(`WA_REVERSE_ANGLE, 12'h400);
        chk(12'(rotCmd.kind), 12'(ROT_REVERSE));
        chk(rotCmd.in3, 12'h333);
        chk(12'(rotCmd.threeOfThree), 12'h000);
        cyc(8);
        rd(`RA_SYS_STATUS, 12'h010);
        kick();
        lows = 12'h000;
        repeat (12) begin
            cyc(1);
            if (irqN === 1'b0)
                lows++;
        end
        chk(lows, 12'(`IRQ_PULSE_CYCLES));
        rd(`RA_SYS_STATUS, 12'h811);
        wr(`WA_SYS_CONTROL, 12'h000);
        kick();
        cyc(6);
        chk(12'(irqN), 12'h001);
        rd(`RA_SYS_STATUS, 12'h010);
        endSim();
    end
endmodule
